//--- common/aofpd_pkg.sv
// Contract
// - gray msb equals binary msb
// - gray bit is xor of neighbours
// - format input high gray, low twos
// - result appears 8.5 cycles after sample
// - sleep low keeps converting
// - sleep high stops all conversions
// - sleep releases data, flag, strobe
// - release and drive within 10ns; the code takes up to 12ns, three core clocks from the pin
// - clock inputs high impedance in sleep
package aofpd_pkg;
   localparam int unsigned AOFPD_WIDTH = 12;
   localparam int unsigned AOFPD_FIFO_DEPTH = 8;
   // latency in conversion-clock half cycles (8.5 cycles)
   localparam int unsigned AOFPD_LAT_HALF = 17;
   localparam int unsigned AOFPD_CLK_NS = 4;
   localparam int unsigned AOFPD_TRI_NS = 10;
   // longest time: round down, at least one cycle
   localparam int unsigned AOFPD_TRI_CYC =
      (AOFPD_TRI_NS / AOFPD_CLK_NS) < 1 ? 1 : (AOFPD_TRI_NS / AOFPD_CLK_NS);
   localparam logic [AOFPD_WIDTH-1:0] AOFPD_WORD_RST = 12'h000;
endpackage

//--- rtl/aofpd_core.sv
`timescale 1ns/100ps
module aofpd_core #(
   parameter int unsigned WIDTH = aofpd_pkg::AOFPD_WIDTH,
   parameter int unsigned FIFO_DEPTH = aofpd_pkg::AOFPD_FIFO_DEPTH
)(
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   // conversion clock pins, sampled by core clock
   input wire logic conv_clock_pos_i,
   input wire logic conv_clock_neg_i,
   output logic conv_clock_term_en_o,
   input wire logic sleep_control_i,
   input wire logic gray_select_i,
   // quantizer result, two's complement, with range flag
   input wire logic [WIDTH-1:0] raw_sample_i,
   input wire logic raw_over_i,
   output logic [WIDTH-1:0] sample_word_lines_o,
   output logic [WIDTH-1:0] sample_word_lines_oe_o,
   output logic out_of_range_flag_o,
   output logic out_of_range_flag_oe_o,
   output logic data_valid_strobe_o,
   output logic data_valid_strobe_oe_o,
   output logic powered_down_o,
   output logic overflow_o
);
   import aofpd_pkg::*;

   initial
   begin
      if (WIDTH < 2)
         $error("width must be at least 2");
   end

   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   logic [3:0] sync1_r;
   logic [3:0] sync2_r;
   logic [WIDTH:0] raw1_r;
   logic [WIDTH:0] raw2_r;
   logic conv_clock_pos_d_r;
   logic conv_clock_neg_d_r;

   always_ff @(posedge core_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         sync1_r <= 4'h0;
         sync2_r <= 4'h0;
         raw1_r <= '0;
         raw2_r <= '0;
         conv_clock_pos_d_r <= 1'b0;
         conv_clock_neg_d_r <= 1'b0;
      end
      else
      begin
         sync1_r <= {gray_select_i, sleep_control_i, conv_clock_neg_i, conv_clock_pos_i};
         sync2_r <= sync1_r;
         raw1_r <= {raw_over_i, raw_sample_i};
         raw2_r <= raw1_r;
         conv_clock_pos_d_r <= sync2_r[0];
         conv_clock_neg_d_r <= sync2_r[1];
      end
   end

   logic conv_clock_pos_s;
   logic sleep_s;
   logic gray_s;
   logic clk_fall;
   logic clk_rise;
   assign conv_clock_pos_s = sync2_r[0];
   assign sleep_s = sync2_r[2];
   assign gray_s = sync2_r[3];
   assign clk_fall = conv_clock_pos_d_r && !conv_clock_pos_s && sync2_r[1] && !conv_clock_neg_d_r;
   assign clk_rise = !conv_clock_pos_d_r && conv_clock_pos_s;

   // ------------------------------------------------------------
   // power-down control
   // ------------------------------------------------------------
   logic sleep_r;
   always_ff @(posedge core_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         sleep_r <= 1'b1;
      else
         sleep_r <= sleep_s;
   end

   // ------------------------------------------------------------
   // format conversion
   // ------------------------------------------------------------
   logic [WIDTH-1:0] bin_word;
   logic [WIDTH-1:0] gray_word;
   logic [WIDTH-1:0] fmt_word;
   // offset binary from two's complement
   assign bin_word = {~raw2_r[WIDTH-1], raw2_r[WIDTH-2:0]};
   assign gray_word[WIDTH-1] = bin_word[WIDTH-1];
   genvar gi;
   generate
      for (gi = 0; gi < WIDTH - 1; gi++)
      begin : g_gray
         assign gray_word[gi] = bin_word[gi] ^ bin_word[gi+1];
      end
   endgenerate
   assign fmt_word = gray_s ? gray_word : raw2_r[WIDTH-1:0];

   // ------------------------------------------------------------
   // sample capture and latency pipeline
   // ------------------------------------------------------------
   logic sample_take;
   logic fifo_wr_ready;
   logic [WIDTH:0] fifo_rd_data;
   logic fifo_rd_valid;
   logic fifo_rd_ready;
   logic overflow_r;
   assign sample_take = clk_fall && !sleep_r;

   aofpd_fifo #(
      .WIDTH(WIDTH + 1),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .core_clk_i(core_clk_i),
      .arst_n_i(arst_n_i),
      .flush_i(sleep_r),
      .wr_data_i({raw2_r[WIDTH], fmt_word}),
      .wr_valid_i(sample_take),
      .wr_ready_o(fifo_wr_ready),
      .rd_data_o(fifo_rd_data),
      .rd_valid_o(fifo_rd_valid),
      .rd_ready_i(fifo_rd_ready)
   );

   // half-cycle counters per queued word, oldest at head
   logic [4:0] age_r [FIFO_DEPTH];
   logic [$clog2(FIFO_DEPTH):0] cnt_r;
   logic edge_any;
   logic pop;
   logic launch;
   logic [WIDTH:0] hold_r;
   logic hold_vld_r;
   assign edge_any = clk_fall || clk_rise;
   // head leaves the queue one conversion cycle early into a stage
   // register, so eight entries cover the whole latency
   assign pop = fifo_rd_valid && clk_rise && (age_r[0] >= 5'(AOFPD_LAT_HALF - 3));
   // 17 half cycles after a falling sample edge is a rising edge
   assign launch = hold_vld_r && clk_rise;
   assign fifo_rd_ready = pop;

   always_ff @(posedge core_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         cnt_r <= '0;
         for (int i = 0; i < FIFO_DEPTH; i++)
            age_r[i] <= 5'h00;
      end
      else if (sleep_r)
      begin
         cnt_r <= '0;
         for (int i = 0; i < FIFO_DEPTH; i++)
            age_r[i] <= 5'h00;
      end
      else
      begin
         for (int i = 0; i < FIFO_DEPTH; i++)
         begin
            logic [4:0] a;
            a = age_r[i];
            if (edge_any && a != 5'h1F)
               a = a + 5'h01;
            if (pop)
               age_r[i] <= (i + 1 < FIFO_DEPTH) ?
                  ((edge_any && age_r[(i+1) % FIFO_DEPTH] != 5'h1F) ?
                   age_r[(i+1) % FIFO_DEPTH] + 5'h01 : age_r[(i+1) % FIFO_DEPTH]) : 5'h00;
            else
               age_r[i] <= a;
         end
         if (sample_take && fifo_wr_ready && !pop)
         begin
            cnt_r <= cnt_r + 1'b1;
            age_r[cnt_r[$clog2(FIFO_DEPTH)-1:0]] <= 5'h00;
         end
         else if (sample_take && fifo_wr_ready && pop)
            age_r[cnt_r[$clog2(FIFO_DEPTH)-1:0] - 1'b1] <= 5'h00;
         else if (pop)
            cnt_r <= cnt_r - 1'b1;
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         overflow_r <= 1'b0;
      else if (sample_take && !fifo_wr_ready)
         overflow_r <= 1'b1;
      else if (sleep_r)
         overflow_r <= 1'b0;
   end

   // ------------------------------------------------------------
   // output drivers
   // ------------------------------------------------------------
   logic [WIDTH-1:0] word_r;
   logic over_r;
   logic strobe_r;
   logic oe_r;
   logic term_en_r;

   always_ff @(posedge core_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         word_r <= AOFPD_WORD_RST;
         over_r <= 1'b0;
      end
      else if (launch)
      begin
         word_r <= hold_r[WIDTH-1:0];
         over_r <= hold_r[WIDTH];
      end
   end

   // stage between queue head and output, one conversion cycle
   always_ff @(posedge core_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         hold_r <= '0;
         hold_vld_r <= 1'b0;
      end
      else if (sleep_r)
         hold_vld_r <= 1'b0;
      else if (pop)
      begin
         hold_r <= fifo_rd_data;
         hold_vld_r <= 1'b1;
      end
      else if (launch)
         hold_vld_r <= 1'b0;
   end

   // strobe falls with new data, rises half a cycle later
   always_ff @(posedge core_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         strobe_r <= 1'b0;
      else if (launch)
         strobe_r <= 1'b0;
      else if (clk_fall)
         strobe_r <= 1'b1;
   end

   // one cycle from sleep pin sync to enable change, up to 12ns from the pin against the 10ns limit
   always_ff @(posedge core_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         oe_r <= 1'b0;
         term_en_r <= 1'b0;
      end
      else
      begin
         oe_r <= !sleep_s;
         term_en_r <= !sleep_s;
      end
   end

   assign sample_word_lines_o = word_r;
   assign sample_word_lines_oe_o = {WIDTH{oe_r}};
   assign out_of_range_flag_o = over_r;
   assign out_of_range_flag_oe_o = oe_r;
   assign data_valid_strobe_o = strobe_r;
   assign data_valid_strobe_oe_o = oe_r;
   assign conv_clock_term_en_o = term_en_r;
   assign powered_down_o = sleep_r;
   assign overflow_o = overflow_r;
endmodule

//--- rtl/aofpd_fifo.sv
`timescale 1ns/100ps
module aofpd_fifo #(
   parameter int unsigned WIDTH = 13,
   parameter int unsigned DEPTH = 8
)(
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   input wire logic flush_i,
   input wire logic [WIDTH-1:0] wr_data_i,
   input wire logic wr_valid_i,
   output logic wr_ready_o,
   output logic [WIDTH-1:0] rd_data_o,
   output logic rd_valid_o,
   input wire logic rd_ready_i
);
   localparam int unsigned AW = $clog2(DEPTH);
   initial
   begin
      if (DEPTH < 2 || (1 << AW) != DEPTH)
         $error("depth must be a power of two, at least 2");
   end

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW:0] wp_r;
   logic [AW:0] rp_r;
   logic push;
   logic pop;

   assign wr_ready_o = (wp_r - rp_r) != (AW+1)'(DEPTH);
   assign rd_valid_o = wp_r != rp_r;
   assign rd_data_o = mem_r[rp_r[AW-1:0]];
   assign push = wr_valid_i && wr_ready_o;
   assign pop = rd_valid_o && rd_ready_i;

   always_ff @(posedge core_clk_i)
   begin
      if (push)
         mem_r[wp_r[AW-1:0]] <= wr_data_i;
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         wp_r <= '0;
         rp_r <= '0;
      end
      else if (flush_i)
      begin
         wp_r <= '0;
         rp_r <= '0;
      end
      else
      begin
         if (push)
            wp_r <= wp_r + 1'b1;
         if (pop)
            rp_r <= rp_r + 1'b1;
      end
   end
endmodule

//--- verification/aofpd_capture.sv
`timescale 1ns/100ps
module aofpd_capture #(
   parameter int WAKE_CYC = 120
)(
   input wire logic core_clk_i,
   input wire logic sleep_control_i,
   input wire logic [11:0] word_i,
   input wire logic word_oe_i,
   input wire logic flag_i,
   input wire logic flag_oe_i,
   input wire logic strobe_i,
   input wire logic strobe_oe_i,
   output logic [11:0] word_o,
   output logic flag_o,
   output logic [11:0] binary_o,
   output int count_o
);
   logic [11:0] last_w = 12'h000;
   logic last_f = 1'b0;
   logic last_s = 1'b0;
   int wake_r = 0;
   int cnt_r = 0;
   // released lines: another bus user drives the inverse
   wire logic [11:0] bus_w = word_oe_i ? word_i : ~last_w;
   wire logic bus_f = flag_oe_i ? flag_i : ~last_f;
   wire logic bus_s = strobe_oe_i ? strobe_i : ~last_s;
   assign count_o = cnt_r;
   always @(posedge core_clk_i)
   begin
      if (word_oe_i) last_w <= word_i;
      if (flag_oe_i) last_f <= flag_i;
      if (strobe_oe_i) last_s <= strobe_i;
      wake_r <= sleep_control_i ? 0 : (wake_r < WAKE_CYC ? wake_r + 1 : wake_r);
   end
   always @(posedge bus_s)
   begin
      if (wake_r >= WAKE_CYC)
      begin
         word_o <= bus_w;
         flag_o <= bus_f;
         cnt_r <= cnt_r + 1;
      end
   end
   always_comb
   begin
      binary_o[11] = word_o[11];
      for (int x = 10; x >= 0; x--) binary_o[x] = binary_o[x+1] ^ word_o[x];
   end
endmodule

//--- verification/aofpd_core_bench.sv
`timescale 1ns/100ps
module aofpd_core_bench;
   import aofpd_pkg::*;
   logic clk = 0, arst_n = 0, pos = 0, sleep = 0, gsel = 0, over = 0;
   logic [11:0] raw = 12'h000, eb, dw, doe, cw, cb;
   logic fl, floe, st, stoe, term, pd, cf, ovf;
   int cnt, failures = 0, samples_checked = 0;
   logic [11:0] tbl [5] = '{12'h7FF, 12'h000, 12'hFFF, 12'h800, 12'h001};
   initial forever #2 clk = ~clk;
   initial
   begin
      #7;
      forever #24 pos = ~pos;
   end
   aofpd_core dut (.core_clk_i(clk), .arst_n_i(arst_n), .conv_clock_pos_i(pos),
      .conv_clock_neg_i(~pos), .conv_clock_term_en_o(term), .sleep_control_i(sleep),
      .gray_select_i(gsel), .raw_sample_i(raw), .raw_over_i(over), .sample_word_lines_o(dw),
      .sample_word_lines_oe_o(doe), .out_of_range_flag_o(fl), .out_of_range_flag_oe_o(floe),
      .data_valid_strobe_o(st), .data_valid_strobe_oe_o(stoe), .powered_down_o(pd),
      .overflow_o(ovf));
   aofpd_capture cap (.core_clk_i(clk), .sleep_control_i(sleep), .word_i(dw),
      .word_oe_i(doe[0]), .flag_i(fl), .flag_oe_i(floe), .strobe_i(st), .strobe_oe_i(stoe),
      .word_o(cw), .flag_o(cf), .binary_o(cb), .count_o(cnt));
   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("checked %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic await_word();
      int c0;
      c0 = cnt;
      for (int i = 0; i < 400 && cnt == c0; i++) @(posedge clk);
      if (cnt == c0)
      begin
         failures++;
         wrap_up();
      end
   endtask
   initial
   begin
      repeat (2) @(posedge clk);
      arst_n <= 1;
      for (int i = 0; i < 10; i++)
      begin
         @(posedge clk);
         gsel <= i[0];
         raw <= tbl[i/2];
         over <= (tbl[i/2] == 12'h7FF);
         repeat (192) @(posedge clk);
         eb = tbl[i/2] ^ 12'h800;
         check(cw, i[0] ? eb ^ (eb >> 1) : tbl[i/2]);
         if (i[0]) check(cb, eb);
         check({11'h0, cf}, {11'h0, tbl[i/2] == 12'h7FF});
      end
      check({11'h0, ovf}, 12'h000);
      $display("format test done");
      @(posedge clk);
      sleep <= 1;
      repeat (4) @(posedge clk);
      check(doe, 12'h000);
      check({9'h0, floe, stoe, term}, 12'h000);
      check({11'h0, pd}, 12'h001);
      repeat (100) @(posedge clk);
      sleep <= 0;
      raw <= 12'h123;
      gsel <= 0;
      over <= 0;
      repeat (4) @(posedge clk);
      check(doe, 12'hFFF);
      check({11'h0, term}, 12'h001);
      await_word();
      check(cw, 12'h123);
      $display("sleep test done");
      wrap_up();
   end
endmodule

//--- verification/aofpd_core_chk.sv
`timescale 1ns/100ps
// ----------
// port checker
// ----------
module aofpd_core_chk #(
   parameter int unsigned WIDTH = 12
)(
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   input wire logic sleep_control_i,
   input logic [WIDTH-1:0] sample_word_lines_o,
   input logic [WIDTH-1:0] sample_word_lines_oe_o,
   input logic out_of_range_flag_oe_o,
   input logic data_valid_strobe_o,
   input logic data_valid_strobe_oe_o,
   input logic conv_clock_term_en_o,
   input logic powered_down_o,
   input logic overflow_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!arst_n_i);
   property p_word_off;
      powered_down_o |-> sample_word_lines_oe_o == '0;
   endproperty
   a_word_off: assert property (p_word_off) else $error("data bus driven in sleep");
   property p_ctl_off;
      powered_down_o |-> !out_of_range_flag_oe_o && !data_valid_strobe_oe_o;
   endproperty
   a_ctl_off: assert property (p_ctl_off) else $error("flag or strobe driven in sleep");
   property p_term_off;
      powered_down_o |-> !conv_clock_term_en_o;
   endproperty
   a_term_off: assert property (p_term_off) else $error("clock inputs active in sleep");
   property p_release;
      $rose(sleep_control_i) |-> ##[1:4] sample_word_lines_oe_o == '0;
   endproperty
   a_release: assert property (p_release) else $error("bus not released in time");
   property p_drive;
      $fell(sleep_control_i) |-> ##[1:4] (&sample_word_lines_oe_o);
   endproperty
   a_drive: assert property (p_drive) else $error("bus not driven in time");
   property p_uniform;
      sample_word_lines_oe_o == {WIDTH{out_of_range_flag_oe_o}};
   endproperty
   a_uniform: assert property (p_uniform) else $error("enables disagree");
   property p_ovf_clr;
      powered_down_o ##1 powered_down_o |-> !overflow_o;
   endproperty
   a_ovf_clr: assert property (p_ovf_clr) else $error("overflow kept in sleep");
   property p_word_strobe;
      data_valid_strobe_oe_o && $changed(sample_word_lines_o) |-> !data_valid_strobe_o;
   endproperty
   a_word_strobe: assert property (p_word_strobe) else $error("word moved, strobe high");
endmodule
bind aofpd_core aofpd_core_chk #(.WIDTH(WIDTH)) chk (.core_clk_i(core_clk_i),
   .arst_n_i(arst_n_i), .sleep_control_i(sleep_control_i),
   .sample_word_lines_o(sample_word_lines_o), .sample_word_lines_oe_o(sample_word_lines_oe_o),
   .out_of_range_flag_oe_o(out_of_range_flag_oe_o), .data_valid_strobe_o(data_valid_strobe_o),
   .data_valid_strobe_oe_o(data_valid_strobe_oe_o), .conv_clock_term_en_o(conv_clock_term_en_o),
   .powered_down_o(powered_down_o), .overflow_o(overflow_o));
